// ==== logic/reset_sequencer_pkg.sv ====
// Constants, types and timing counts shared by the reset sequencer.
// Assumes a single 200 MHz system clock that also stands in for the
// oscillator clock used to count the settle wait.
// Overview of operation
// - Power-on, low supply, external pin low or watchdog expiry force the reset state.
// - During reset, registers with defined values load them; others keep contents.
// - Power-on or low-supply reset sets watchdog-clean and awake flags to one.
// - External pin reset outside halt leaves both flags unchanged.
// - External pin reset during halt sets both flags to one.
// - Watchdog reset outside halt clears watchdog-clean, sets awake.
// - Watchdog reset during halt clears both flags.
// - Halt instruction gives flags 1 and 0; watchdog clear gives both one.
// - After all causes release, wait the power-up period whatever oscillator.
// - Three-bit setting picks 140us, 4.5ms, 18ms, 72ms or 288ms.
// - With 140us power-up, settle wait lasts exactly one clock.
// - With longer power-up, settle wait lasts sixteen clocks.
// - Execution starts only after power-up and settle wait both finish.
// - First run cycle is fast when startup setting says fast, else slow; then mode follows fast select.
// - Halt stops both oscillators, all peripherals and instruction execution.
// - Halt ends on any reset cause, port change or interrupt; on wake, mode follows fast select.
package reset_sequencer_pkg;

  // Clock and counter sizing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CNT_W         = 26;

  // Power-up periods in their own unit
  localparam int T_PU_140US_NS = 140000;
  localparam int T_PU_4M5_NS   = 4500000;
  localparam int T_PU_18MS_NS  = 18000000;
  localparam int T_PU_72MS_NS  = 72000000;
  localparam int T_PU_288MS_NS = 288000000;

  // Power-up periods in clock cycles, least time so rounded up
  localparam logic [CNT_W-1:0] PU_140US_CYC = CNT_W'((T_PU_140US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PU_4M5_CYC   = CNT_W'((T_PU_4M5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PU_18MS_CYC  = CNT_W'((T_PU_18MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PU_72MS_CYC  = CNT_W'((T_PU_72MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PU_288MS_CYC = CNT_W'((T_PU_288MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Power-up select encodings; codes 4 to 7 all pick the longest period
  localparam logic [2:0] PU_SEL_140US = 3'h0;
  localparam logic [2:0] PU_SEL_4M5   = 3'h1;
  localparam logic [2:0] PU_SEL_18MS  = 3'h2;
  localparam logic [2:0] PU_SEL_72MS  = 3'h3;

  // Oscillator settle wait in clock cycles
  localparam logic [CNT_W-1:0] SETTLE_SHORT_CYC = 26'h0000001;
  localparam logic [CNT_W-1:0] SETTLE_LONG_CYC  = 26'h0000010;

  // Synchroniser depth and reset values of the asynchronous causes
  localparam int         SYNC_DEPTH   = 3;
  localparam logic [2:0] ASYNC_RESET  = 3'h4;  // {pin_n, low supply, power-on}
  localparam int         BIT_POWER_ON = 0;
  localparam int         BIT_LOW_SUP  = 1;
  localparam int         BIT_PIN_N    = 2;

  // Flag values
  localparam logic [1:0] FLAGS_BOTH_SET = 2'h3;

  // Control outputs while held in reset: both oscillators on, peripherals idle, slow
  localparam logic [3:0] CONTROLS_RESET = 4'hc;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_RESET   = 5'h01,
    ST_POWERUP = 5'h02,
    ST_SETTLE  = 5'h04,
    ST_RUN     = 5'h08,
    ST_HALT    = 5'h10
  } seq_state_type;

  // Reset causes after conditioning
  typedef struct packed {
    logic power_on;
    logic low_supply;
    logic external_pin;
    logic watchdog;
  } reset_causes_type;

  // Reset-cause status flags
  typedef struct packed {
    logic watchdog_clean_flag;
    logic awake_flag;
  } status_flags_type;

  // Clock and activity controls towards the rest of the chip
  typedef struct packed {
    logic fast_osc_enable;
    logic slow_osc_enable;
    logic periph_enable;
    logic fast_mode;
  } run_controls_type;

endpackage : reset_sequencer_pkg

// ==== logic/mcu_reset_sequencer.sv ====
// Reset sequencer: gathers reset causes, times the power-up and settle waits,
// keeps the reset-cause flags and the run, slow and halt mode controls.
// Assumes watchdog, instruction and wake strobes come from logic on i_ref_clk;
// detector outputs and the reset pin are asynchronous and synchronised here.
`timescale 1ns/10ps
module mcu_reset_sequencer
  import reset_sequencer_pkg::*;
#(
  parameter logic [reset_sequencer_pkg::CNT_W-1:0] PU_140US = reset_sequencer_pkg::PU_140US_CYC,
  parameter logic [reset_sequencer_pkg::CNT_W-1:0] PU_4M5   = reset_sequencer_pkg::PU_4M5_CYC,
  parameter logic [reset_sequencer_pkg::CNT_W-1:0] PU_18MS  = reset_sequencer_pkg::PU_18MS_CYC,
  parameter logic [reset_sequencer_pkg::CNT_W-1:0] PU_72MS  = reset_sequencer_pkg::PU_72MS_CYC,
  parameter logic [reset_sequencer_pkg::CNT_W-1:0] PU_288MS = reset_sequencer_pkg::PU_288MS_CYC
)(
  input  wire logic                                 i_ref_clk,
  input  wire logic                                 i_reset_n,
  input  wire logic                                 i_power_on_detect,
  input  wire logic                                 i_low_supply_reset,
  input  wire logic                                 i_external_reset_pin_n,
  input  wire logic                                 i_watchdog_expire,
  input  wire logic                                 i_halt_instruction,
  input  wire logic                                 i_watchdog_clear_instruction,
  input  wire logic                                 i_wake_event,
  input  wire logic [2:0]                           i_powerup_select,
  input  wire logic                                 i_startup_fast,
  input  wire logic                                 i_fast_clock_select,
  input  wire logic                                 i_fast_osc_stop,
  output logic                                      o_core_reset,
  output logic                                      o_load_defaults,
  output logic                                      o_run,
  output reset_sequencer_pkg::status_flags_type     o_flags,
  output reset_sequencer_pkg::run_controls_type     o_controls
);
  import reset_sequencer_pkg::*;

  logic [2:0]             async_in;
  logic [2:0]             sync1;
  logic [2:0]             sync2;
  logic [2:0]             sync3;
  logic [2:0]             async_filt;
  reset_causes_type       causes;
  logic                   any_cause;
  seq_state_type          state;
  seq_state_type          next_state;
  logic [CNT_W-1:0]       count;
  logic                   count_done;
  logic                   short_powerup;
  logic [CNT_W-1:0]       powerup_len;
  status_flags_type       flags;
  run_controls_type       next_controls;
  run_controls_type       controls;

  assign async_in = {i_external_reset_pin_n, i_low_supply_reset, i_power_on_detect};

  // Three-stage synchroniser per asynchronous cause; a change counts when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_DEPTH; gi++)
    begin : g_sync
      always_ff @(posedge i_ref_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          sync1[gi]      <= ASYNC_RESET[gi];
          sync2[gi]      <= ASYNC_RESET[gi];
          sync3[gi]      <= ASYNC_RESET[gi];
          async_filt[gi] <= ASYNC_RESET[gi];
        end
        else
        begin
          sync1[gi] <= async_in[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi])
            async_filt[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  // Conditioned reset causes
  assign causes.power_on     = async_filt[BIT_POWER_ON];
  assign causes.low_supply   = async_filt[BIT_LOW_SUP];
  assign causes.external_pin = ~async_filt[BIT_PIN_N];
  assign causes.watchdog     = i_watchdog_expire;
  assign any_cause           = |causes;

  // Power-up period from the three-bit setting
  always_comb
  begin
    case (i_powerup_select)
      PU_SEL_140US: powerup_len = PU_140US;
      PU_SEL_4M5:   powerup_len = PU_4M5;
      PU_SEL_18MS:  powerup_len = PU_18MS;
      PU_SEL_72MS:  powerup_len = PU_72MS;
      default:      powerup_len = PU_288MS;
    endcase
  end

  assign count_done = (count == '0);

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    if (any_cause)
      next_state = ST_RESET;
    else
    begin
      case (state)
        ST_RESET:   next_state = ST_POWERUP;
        ST_POWERUP: if (count_done) next_state = ST_SETTLE;
        ST_SETTLE:  if (count_done) next_state = ST_RUN;
        ST_RUN:     if (i_halt_instruction) next_state = ST_HALT;
        ST_HALT:    if (i_wake_event) next_state = ST_RUN;
        default:    next_state = ST_RESET;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state <= ST_RESET;
    else
      state <= next_state;
  end

  // Power-up and settle down-counter; the settle length follows the latched period choice
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      count         <= '0;
      short_powerup <= 1'b0;
    end
    else if (state == ST_RESET)
    begin
      count         <= powerup_len - CNT_W'(1);
      short_powerup <= (i_powerup_select == PU_SEL_140US);
    end
    else if (state == ST_POWERUP && count_done)
      count <= short_powerup ? SETTLE_SHORT_CYC - CNT_W'(1)
                             : SETTLE_LONG_CYC - CNT_W'(1);
    else if (!count_done)
      count <= count - CNT_W'(1);
  end

  // Reset-cause flags; power-on also comes from the block's own reset
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      flags <= FLAGS_BOTH_SET;
    else if (causes.power_on || causes.low_supply)
      flags <= FLAGS_BOTH_SET;
    else if (causes.watchdog)
    begin
      flags.watchdog_clean_flag <= 1'b0;
      flags.awake_flag          <= (state != ST_HALT);
    end
    else if (causes.external_pin)
    begin
      if (state == ST_HALT)
        flags <= FLAGS_BOTH_SET;
    end
    else if (state == ST_RUN && i_halt_instruction)
    begin
      flags.watchdog_clean_flag <= 1'b1;
      flags.awake_flag          <= 1'b0;
    end
    else if (state == ST_RUN && i_watchdog_clear_instruction)
      flags <= FLAGS_BOTH_SET;
  end

  // Mode and oscillator controls for the next state
  always_comb
  begin
    next_controls                 = controls;
    next_controls.fast_osc_enable = 1'b1;
    next_controls.slow_osc_enable = 1'b1;
    next_controls.periph_enable   = 1'b0;
    case (next_state)
      ST_RESET, ST_POWERUP, ST_SETTLE:
        next_controls.fast_mode = i_startup_fast;
      ST_RUN:
      begin
        if (state == ST_RUN || state == ST_HALT)
          next_controls.fast_mode = i_fast_clock_select;
        next_controls.periph_enable   = 1'b1;
        next_controls.fast_osc_enable = next_controls.fast_mode | ~i_fast_osc_stop;
      end
      ST_HALT:
      begin
        next_controls.fast_osc_enable = 1'b0;
        next_controls.slow_osc_enable = 1'b0;
      end
      default:
        next_controls.fast_mode = i_startup_fast;
    endcase
  end

  // Registered control outputs
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      controls <= CONTROLS_RESET;                                    // Oscillators on, idle, slow
    else
      controls <= next_controls;
  end

  // Outputs
  assign o_flags         = flags;
  assign o_controls      = controls;
  assign o_core_reset    = (state == ST_RESET) || (state == ST_POWERUP) || (state == ST_SETTLE);
  assign o_load_defaults = (state == ST_RESET);
  assign o_run           = (state == ST_RUN);

  // Helper: cycles spent in the power-up wait
  logic [CNT_W-1:0] pu_cycles;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pu_cycles <= '0;
    else if (state == ST_POWERUP)
      pu_cycles <= pu_cycles + CNT_W'(1);
    else
      pu_cycles <= '0;
  end

  // Checks
  // Sixteen settle cycles with execution still held off
  sequence settle_hold_s;
    (!o_run)[*8] ##1 (!o_run)[*8];
  endsequence

  sequence enter_settle_s;
    $rose(state == ST_SETTLE);
  endsequence

  cause_entry_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    any_cause |=> state == ST_RESET) else $error("Reset cause did not enter reset");

  poweron_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (causes.power_on || causes.low_supply) |=> o_flags == FLAGS_BOTH_SET)
    else $error("Power-on flags wrong");

  pin_run_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (causes == 4'h2 && state != ST_HALT) |=> o_flags == $past(o_flags))
    else $error("Pin reset outside halt changed flags");

  pin_halt_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (causes == 4'h2 && state == ST_HALT) |=> o_flags == FLAGS_BOTH_SET)
    else $error("Pin reset in halt flags wrong");

  wdt_run_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (causes == 4'h1 && state != ST_HALT) |=> o_flags == 2'h1)
    else $error("Watchdog reset outside halt flags wrong");

  wdt_halt_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (causes == 4'h1 && state == ST_HALT) |=> o_flags == 2'h0)
    else $error("Watchdog reset in halt flags wrong");

  halt_instr_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!any_cause && o_run && i_halt_instruction) |=> o_flags == 2'h2 && state == ST_HALT)
    else $error("Halt instruction flags wrong");

  powerup_length_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    enter_settle_s |-> $past(pu_cycles) + CNT_W'(1) == $past(powerup_len))
    else $error("Power-up period length wrong");

  settle_short_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (enter_settle_s and short_powerup) |-> !o_run ##1 (o_run || state == ST_RESET))
    else $error("Short settle wait not one cycle");

  settle_long_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (enter_settle_s and !short_powerup) |-> settle_hold_s ##1 (o_run || state != ST_SETTLE))
    else $error("Long settle wait not sixteen cycles");

  exec_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(o_run) |-> $past(state == ST_SETTLE) || $past(state == ST_HALT))
    else $error("Execution started early");

  halt_osc_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (state == ST_HALT) |-> !o_run && o_controls[3:1] == 3'h0)
    else $error("Oscillators running in halt");

  wake_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (state == ST_HALT && i_wake_event && !any_cause) |=> o_run && o_controls.fast_mode == $past(i_fast_clock_select))
    else $error("Wake from halt wrong");

  // Release of every cause moves reset on to the power-up wait
  powerup_entry_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (state == ST_RESET && !any_cause) |=> state == ST_POWERUP && o_core_reset && !o_run)
    else $error("Power-up wait not entered after release");

  // First run cycle after the waits follows the startup clock setting
  startup_mode_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ($rose(o_run) && $past(state == ST_SETTLE)) |-> o_controls.fast_mode == $past(i_startup_fast, 2))
    else $error("Startup mode wrong");

  // A cause during either wait goes back to the reset state
  restart_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (any_cause && (state == ST_POWERUP || state == ST_SETTLE)) |=> o_load_defaults && o_core_reset)
    else $error("Cause during waits did not restart");

  // Watchdog clear in run sets both flags
  clear_flags_a: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (!any_cause && o_run && !i_halt_instruction && i_watchdog_clear_instruction) |=> o_flags == FLAGS_BOTH_SET)
    else $error("Watchdog clear flags wrong");

endmodule : mcu_reset_sequencer

// ==== bench/tb.sv ====
// Self-checking bench for the reset sequencer: drives every cause, instruction
// strobe and setting itself, with power-up counts shortened to 20..100 cycles.
`timescale 1ns/10ps
module tb;
  import reset_sequencer_pkg::*;

  logic             i_ref_clk, i_reset_n, i_power_on_detect, i_low_supply_reset;
  logic             i_external_reset_pin_n, i_watchdog_expire, i_halt_instruction;
  logic             i_watchdog_clear_instruction, i_wake_event, i_startup_fast;
  logic             i_fast_clock_select, i_fast_osc_stop;
  logic [2:0]       i_powerup_select;
  logic             o_core_reset, o_load_defaults, o_run;
  status_flags_type o_flags;
  run_controls_type o_controls;
  int               n_errors, comparisons;
  int               pu_tab [8] = '{20, 40, 60, 80, 100, 100, 100, 100};

  mcu_reset_sequencer #(.PU_140US(26'h14), .PU_4M5(26'h28), .PU_18MS(26'h3c), .PU_72MS(26'h50),
    .PU_288MS(26'h64)) u_mcu_reset_sequencer (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_power_on_detect(i_power_on_detect), .i_low_supply_reset(i_low_supply_reset),
    .i_external_reset_pin_n(i_external_reset_pin_n), .i_watchdog_expire(i_watchdog_expire),
    .i_halt_instruction(i_halt_instruction), .i_watchdog_clear_instruction(i_watchdog_clear_instruction),
    .i_wake_event(i_wake_event), .i_powerup_select(i_powerup_select), .i_startup_fast(i_startup_fast),
    .i_fast_clock_select(i_fast_clock_select), .i_fast_osc_stop(i_fast_osc_stop),
    .o_core_reset(o_core_reset), .o_load_defaults(o_load_defaults), .o_run(o_run),
    .o_flags(o_flags), .o_controls(o_controls));

  // 200 MHz clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // Counts wait cycles since the latest reset state, sampled at the falling edge
  int               wait_cnt, ld_count, ld_taken;
  always @(negedge i_ref_clk)
  begin
    if (o_load_defaults === 1'b1)
    begin
      wait_cnt = 0;
      ld_count++;
    end
    else if (o_core_reset === 1'b1)
      wait_cnt++;
  end

  // Compare and count
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One-cycle strobe: 0 watchdog, 1 halt, 2 clear, 3 wake
  task automatic strobe(input int k);
    @(posedge i_ref_clk);
    case (k)
      0: i_watchdog_expire <= 1'b1;
      1: i_halt_instruction <= 1'b1;
      2: i_watchdog_clear_instruction <= 1'b1;
      default: i_wake_event <= 1'b1;
    endcase
    @(posedge i_ref_clk);
    {i_watchdog_expire, i_halt_instruction, i_watchdog_clear_instruction, i_wake_event} <= 4'h0;
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask : strobe

  // Hold an asynchronous cause for some cycles: 0 power-on, 1 low supply, 2 pin low
  task automatic hold_cause(input int k, input int cyc);
    @(posedge i_ref_clk);
    if (k == 0) i_power_on_detect <= 1'b1;
    else if (k == 1) i_low_supply_reset <= 1'b1;
    else i_external_reset_pin_n <= 1'b0;
    repeat (cyc) @(posedge i_ref_clk);
    i_power_on_detect <= 1'b0;
    i_low_supply_reset <= 1'b0;
    i_external_reset_pin_n <= 1'b1;
  endtask : hold_cause

  // Count power-up plus settle cycles until execution starts; restarts count on reset state
  task automatic wait_run(input int exp_n, input string what);
    for (int i = 0; i < 600 && o_run !== 1'b1; i++)
    begin
      @(posedge i_ref_clk);
      #1;
    end
    chk(4'(ld_count != ld_taken), 4'h1, {what, " reset state"});
    ld_taken = ld_count;
    chk(4'(o_run), 4'h1, {what, " run"});
    chk(wait_cnt[3:0], exp_n[3:0], {what, " wait low"});
    chk(wait_cnt[7:4], exp_n[7:4], {what, " wait high"});
  endtask : wait_run

  // Power-on: flags set, shortest period, fast startup
  task automatic t_power_on;
    wait_run(21, "power-on");
    chk(4'(o_flags), 4'h3, "power-on flags");
    chk(4'(o_controls), 4'hf, "fast startup");
  endtask : t_power_on

  // Select codes 1 to 7 through a watchdog reset from run
  task automatic t_selects;
    for (int c = 1; c < 8; c++)
    begin
      i_powerup_select <= 3'(c);
      strobe(0);
      chk(4'(o_flags), 4'h1, "watchdog from run flags");
      chk(4'(o_run), 4'h0, "watchdog stops run");
      wait_run(pu_tab[c] + 16, "select");
    end
    i_powerup_select <= 3'h0;
  endtask : t_selects

  // Pin reset outside halt keeps flags, from halt sets both
  task automatic t_pin;
    hold_cause(2, 8);
    wait_run(21, "pin");
    chk(4'(o_flags), 4'h1, "pin from run flags");
    strobe(1);
    chk(4'(o_flags), 4'h2, "halt flags");
    hold_cause(2, 8);
    wait_run(21, "pin from halt");
    chk(4'(o_flags), 4'h3, "pin from halt flags");
  endtask : t_pin

  // Halt stops everything, clear does not leave it but wake does, mode follows fast select
  task automatic t_halt_wake;
    i_startup_fast <= 1'b0;
    strobe(0);
    wait_run(21, "slow startup");
    chk(4'(o_controls), 4'he, "slow startup controls");
    i_fast_osc_stop <= 1'b1;
    strobe(3);
    chk(4'(o_controls), 4'h6, "fast osc stopped in slow run");
    i_fast_osc_stop <= 1'b0;
    strobe(1);
    chk({o_run, o_controls[2:0]}, 4'h0, "halt stops all");
    chk(4'(o_controls[3]), 4'h0, "halt stops fast osc");
    strobe(2);
    chk(4'(o_run), 4'h0, "clear does not wake");
    chk(4'(o_flags), 4'h2, "clear ignored in halt");
    i_fast_clock_select <= 1'b1;
    strobe(3);
    chk({o_run, 3'h0}, 4'h8, "wake resumes");
    chk(4'(o_controls), 4'hf, "wake to fast");
    strobe(2);
    chk(4'(o_flags), 4'h3, "clear flags");
  endtask : t_halt_wake

  // Watchdog reset while halted clears both flags
  task automatic t_wd_halt;
    strobe(1);
    strobe(0);
    chk(4'(o_flags), 4'h0, "watchdog from halt flags");
    wait_run(21, "watchdog from halt");
  endtask : t_wd_halt

  // Detectors, and a cause in mid power-up restarting the sequence
  task automatic t_detectors;
    for (int k = 0; k < 2; k++)
    begin
      strobe(0);
      hold_cause(k, 6);
      wait_run(21, "detector");
      chk(4'(o_flags), 4'h3, "detector flags");
    end
    i_powerup_select <= 3'h1;
    strobe(0);
    repeat (12) @(posedge i_ref_clk);
    #1;
    chk({o_core_reset, o_load_defaults, 2'h0}, 4'h8, "in power-up");
    hold_cause(1, 4);
    wait_run(pu_tab[1] + 16, "restart");
    chk(4'(o_flags), 4'h3, "restart flags");
  endtask : t_detectors

  // Verdict
  task automatic end_of_test;
    $display("Errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Hang guard, far beyond the roughly 1100 cycles the tests take
  initial
  begin
    repeat (40000) @(posedge i_ref_clk);
    n_errors++;
    $display("ERROR t=%0t watchdog of the bench expired", $time);
    end_of_test();
  end

  // Main sequence
  initial
  begin
    n_errors = 0;
    comparisons = 0;
    {i_reset_n, i_power_on_detect, i_low_supply_reset, i_watchdog_expire} = 4'h0;
    {i_halt_instruction, i_watchdog_clear_instruction, i_wake_event, i_fast_osc_stop} = 4'h0;
    i_external_reset_pin_n = 1'b1;
    i_powerup_select = 3'h0;
    i_startup_fast = 1'b1;
    i_fast_clock_select = 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    t_power_on();
    t_selects();
    t_pin();
    t_halt_wake();
    t_wd_halt();
    t_detectors();
    end_of_test();
  end
endmodule : tb
